// *** hw/sefp_pkg.sv ***
package sefp_pkg;

    // Two-bit function codes.
    localparam logic [1:0] SEFP_CODE_OFF   = 2'h0;
    localparam logic [1:0] SEFP_CODE_ON    = 2'h1;
    localparam logic [1:0] SEFP_CODE_RSVD  = 2'h2;
    localparam logic [1:0] SEFP_CODE_NSUP  = 2'h3;

    // Constant filler values.
    localparam logic [3:0] SEFP_FILL_NIB   = 4'hf;
    localparam logic [7:0] SEFP_BYTE_RESET = 8'hff;
    localparam logic [1:0] SEFP_BYTE2_RESET = 2'h3;
    localparam logic [5:0] SEFP_BYTE6_RESET = 6'h3f;

    // Field positions (lsb of each pair) inside their byte.
    localparam int SEFP_POS_B2_OPER   = 6;
    localparam int SEFP_POS_B3_FILL   = 0;
    localparam int SEFP_POS_B3_MODE   = 4;
    localparam int SEFP_POS_B3_LOAD   = 6;
    localparam int SEFP_POS_B4_KICK   = 0;
    localparam int SEFP_POS_B4_DRIVE  = 2;
    localparam int SEFP_POS_B4_RSVD   = 4;
    localparam int SEFP_POS_B4_INHIB  = 6;
    localparam int SEFP_POS_B5_SEAT   = 0;
    localparam int SEFP_POS_B5_RSVD   = 2;
    localparam int SEFP_POS_B5_IDLE   = 4;
    localparam int SEFP_POS_B5_FULL   = 6;
    localparam int SEFP_POS_B6_LOCK   = 0;
    localparam int SEFP_POS_B6_HIDLE  = 2;
    localparam int SEFP_POS_B6_RANGE  = 4;

    // Number of two-bit function fields taken from the controller.
    localparam int SEFP_NFUNC = 12;

endpackage

// *** hw/sefp_field_enc.sv ***
`timescale 1ns/1ps
module sefp_field_enc
    import sefp_pkg::*;
(
    input  wire logic       i_supported,
    input  wire logic       i_state,
    output logic [1:0]      o_code
);

    // A field is either a clean 00/01 state or all ones; 10 is never produced.
    always_comb begin
        if (i_supported) begin
            o_code = i_state ? SEFP_CODE_ON : SEFP_CODE_OFF;
        end else begin
            o_code = SEFP_CODE_NSUP;
        end
    end

endmodule

// *** hw/sefp_frame_packer.sv ***
`timescale 1ns/1ps
module sefp_frame_packer
    import sefp_pkg::*;
(
    input  wire logic                  i_clk,
    input  wire logic                  i_reset_n,
    input  wire logic [SEFP_NFUNC-1:0] i_state,
    input  wire logic [SEFP_NFUNC-1:0] i_supported,
    output logic      [1:0]            o_byte2_hi,
    output logic      [7:0]            o_byte3,
    output logic      [7:0]            o_byte4,
    output logic      [7:0]            o_byte5,
    output logic      [5:0]            o_byte6_lo
);

    ////////////////////////////////////////////////////////////////////////////
    // Per-function encoders. Index: 0 operator, 1 mode, 2 load, 3 kickdown,
    // 4 drive, 5 inhibit, 6 seat, 7 idle, 8 full throttle, 9 lockup,
    // 10 raised idle, 11 range.

    logic [1:0] code [SEFP_NFUNC];

    genvar g;
    generate
        for (g = 0; g < SEFP_NFUNC; g++) begin : g_enc
            sefp_field_enc u_enc (
                .i_supported (i_supported[g]),
                .i_state     (i_state[g]),
                .o_code      (code[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Payload assembly.

    logic [1:0] byte2_hi_r, byte2_hi_nxt;
    logic [7:0] byte3_r, byte3_nxt;
    logic [7:0] byte4_r, byte4_nxt;
    logic [7:0] byte5_r, byte5_nxt;
    logic [5:0] byte6_lo_r, byte6_lo_nxt;

    always_comb begin
        byte2_hi_nxt = code[0];
        byte3_nxt = {code[2], code[1], SEFP_FILL_NIB};
        byte4_nxt = {code[5], SEFP_CODE_NSUP, code[4], code[3]};
        byte5_nxt = {code[8], code[7], SEFP_CODE_NSUP, code[6]};
        byte6_lo_nxt = {code[11], code[10], code[9]};
    end

    // Every field is captured together on the same edge.
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            byte2_hi_r <= SEFP_BYTE2_RESET;
            byte3_r    <= SEFP_BYTE_RESET;
            byte4_r    <= SEFP_BYTE_RESET;
            byte5_r    <= SEFP_BYTE_RESET;
            byte6_lo_r <= SEFP_BYTE6_RESET;
        end else begin
            byte2_hi_r <= byte2_hi_nxt;
            byte3_r    <= byte3_nxt;
            byte4_r    <= byte4_nxt;
            byte5_r    <= byte5_nxt;
            byte6_lo_r <= byte6_lo_nxt;
        end
    end

    assign o_byte2_hi = byte2_hi_r;
    assign o_byte3    = byte3_r;
    assign o_byte4    = byte4_r;
    assign o_byte5    = byte5_r;
    assign o_byte6_lo = byte6_lo_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    // Expected code of one field from its supported and state bits.
    function automatic logic [1:0] sefp_field_code(input logic supported, input logic state);
        logic [1:0] result;
        result = SEFP_CODE_NSUP;
        if (supported) begin
            result = state ? SEFP_CODE_ON : SEFP_CODE_OFF;
        end
        return result;
    endfunction

    // Flags a byte in which any two-bit pair carries the reserved code.
    function automatic logic sefp_has_rsvd(input logic [7:0] value);
        logic found;
        found = 1'h0;
        for (int k = 0; k < 4; k++) begin
            if (value[2*k +: 2] == SEFP_CODE_RSVD) begin
                found = 1'h1;
            end
        end
        return found;
    endfunction

    // Past values taken during reset say nothing about the payload, so checks that
    // look one edge back, all but chk_load_field, chk_kick_field and chk_inhib_field, wait for one clean edge after every reset.
    logic past_ok_r, past_ok_nxt;

    always_comb begin
        past_ok_nxt = 1'h1;
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            past_ok_r <= 1'h0;
        end else begin
            past_ok_r <= past_ok_nxt;
        end
    end

    chk_oper_field: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        past_ok_r |-> o_byte2_hi
        == sefp_field_code($past(i_supported[0]), $past(i_state[0])))
        else $error("operator field mismatch");

    chk_no_rsvd_code: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        !sefp_has_rsvd({6'h3f, o_byte2_hi}) && !sefp_has_rsvd(o_byte3)
        && !sefp_has_rsvd(o_byte4) && !sefp_has_rsvd(o_byte5)
        && !sefp_has_rsvd({2'h3, o_byte6_lo}))
        else $error("reserved code transmitted");

    chk_fill_nibble: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        o_byte3[3:0] == SEFP_FILL_NIB)
        else $error("byte3 filler not all ones");

    chk_reset_ones: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        !past_ok_r |-> o_byte2_hi == SEFP_BYTE2_RESET && o_byte3 == SEFP_BYTE_RESET
        && o_byte4 == SEFP_BYTE_RESET && o_byte5 == SEFP_BYTE_RESET
        && o_byte6_lo == SEFP_BYTE6_RESET)
        else $error("payload not all ones after reset");

    chk_mode_field: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        past_ok_r && $past(i_supported[1]) |-> o_byte3[5:4] == {1'h0, $past(i_state[1])})
        else $error("mode field mismatch");

    chk_mode_code: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        past_ok_r |-> o_byte3[SEFP_POS_B3_MODE +: 2]
        == sefp_field_code($past(i_supported[1]), $past(i_state[1])))
        else $error("mode code mismatch");

    chk_load_field: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        !$past(i_supported[2]) |-> o_byte3[7:6] == SEFP_CODE_NSUP)
        else $error("load field not all ones when unsupported");

    chk_kick_field: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (i_supported[3] && i_state[3]) |=> o_byte4[1:0] == SEFP_CODE_ON)
        else $error("kickdown echo missing");

    chk_kick_code: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        past_ok_r |-> o_byte4[SEFP_POS_B4_KICK +: 2]
        == sefp_field_code($past(i_supported[3]), $past(i_state[3])))
        else $error("kickdown code mismatch");

    chk_drive_field: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        past_ok_r |-> o_byte4[SEFP_POS_B4_DRIVE +: 2]
        == sefp_field_code($past(i_supported[4]), $past(i_state[4])))
        else $error("drive field mismatch");

    chk_rsvd_pairs: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        o_byte4[5:4] == SEFP_CODE_NSUP && o_byte5[3:2] == SEFP_CODE_NSUP)
        else $error("reserved pair not 11");

    chk_inhib_field: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (i_supported[5] && !i_state[5]) |=> o_byte4[7:6] == SEFP_CODE_OFF)
        else $error("inhibit field mismatch");

    chk_inhib_code: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        past_ok_r |-> o_byte4[SEFP_POS_B4_INHIB +: 2]
        == sefp_field_code($past(i_supported[5]), $past(i_state[5])))
        else $error("inhibit code mismatch");

    chk_seat_field: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        past_ok_r && $past(i_supported[6]) |-> o_byte5[1:0] == {1'h0, $past(i_state[6])})
        else $error("seat field mismatch");

    chk_idle_field: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        past_ok_r |-> o_byte5[SEFP_POS_B5_IDLE +: 2]
        == sefp_field_code($past(i_supported[7]), $past(i_state[7])))
        else $error("pedal idle field mismatch");

    chk_full_field: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        past_ok_r |-> o_byte5[SEFP_POS_B5_FULL +: 2]
        == sefp_field_code($past(i_supported[8]), $past(i_state[8])))
        else $error("full throttle field mismatch");

    chk_lock_field: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        past_ok_r |-> o_byte6_lo[SEFP_POS_B6_LOCK +: 2]
        == sefp_field_code($past(i_supported[9]), $past(i_state[9])))
        else $error("lockup field mismatch");

    chk_hidle_field: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        past_ok_r |-> o_byte6_lo[SEFP_POS_B6_HIDLE +: 2]
        == sefp_field_code($past(i_supported[10]), $past(i_state[10])))
        else $error("raised idle field mismatch");

    chk_range_field: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        past_ok_r && $past(i_supported[11]) |-> o_byte6_lo[5:4] == {1'h0, $past(i_state[11])})
        else $error("range field mismatch");

    chk_same_sample: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        past_ok_r && $past(i_supported[10]) |-> o_byte6_lo[3:2] == {1'h0, $past(i_state[10])}
        && o_byte6_lo[1:0] == ($past(i_supported[9]) ? {1'h0, $past(i_state[9])} : 2'h3))
        else $error("fields not sampled together");

endmodule

// *** verification/sefp_can_reader.sv ***
`timescale 1ns/1ps
module sefp_can_reader (
    input  wire logic [1:0]  i_byte2_hi,
    input  wire logic [7:0]  i_byte3,
    input  wire logic [7:0]  i_byte4,
    input  wire logic [7:0]  i_byte5,
    input  wire logic [5:0]  i_byte6_lo,
    output logic      [31:0] o_frame,
    output logic             o_rsvd_seen
);
    // Joins the received bytes into one payload and flags any reserved code.
    always_comb begin
        o_frame     = {i_byte6_lo, i_byte5, i_byte4, i_byte3, i_byte2_hi};
        o_rsvd_seen = 1'h0;
        for (int k = 0; k < 16; k++) begin
            if (o_frame[2*k +: 2] == 2'h2) begin
                o_rsvd_seen = 1'h1;
            end
        end
    end
endmodule

// *** verification/sefp_frame_packer_tb.sv ***
`timescale 1ns/1ps
module sefp_frame_packer_tb;
    import sefp_pkg::*;
    logic                  i_clk       = 1'h0;
    logic                  i_reset_n   = 1'h0;
    logic [SEFP_NFUNC-1:0] i_state     = 12'h0;
    logic [SEFP_NFUNC-1:0] i_supported = 12'h0;
    logic [1:0]            b2;
    logic [7:0]            b3, b4, b5;
    logic [5:0]            b6;
    logic [31:0]           frame;
    logic                  rsvd;
    int                    errors      = 0;
    int                    comparisons = 0;
    always #5 i_clk = ~i_clk;
    sefp_frame_packer i_dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_state(i_state),
        .i_supported(i_supported), .o_byte2_hi(b2), .o_byte3(b3), .o_byte4(b4),
        .o_byte5(b5), .o_byte6_lo(b6));
    sefp_can_reader i_far (.i_byte2_hi(b2), .i_byte3(b3), .i_byte4(b4), .i_byte5(b5),
        .i_byte6_lo(b6), .o_frame(frame), .o_rsvd_seen(rsvd));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        if (errors == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    function automatic logic [31:0] exp_frame(input logic [11:0] st, input logic [11:0] sup);
        logic [1:0] c [12];
        for (int i = 0; i < 12; i++) c[i] = sup[i] ? {1'h0, st[i]} : SEFP_CODE_NSUP;
        return {c[11], c[10], c[9], c[8], c[7], 2'h3, c[6], c[5], 2'h3, c[4], c[3],
                c[2], c[1], SEFP_FILL_NIB, c[0]};
    endfunction
    // Drives one input set at a falling edge and judges the payload at the next falling edge.
    task automatic apply(input logic [11:0] st, input logic [11:0] sup);
        i_state     = st;
        i_supported = sup;
        @(negedge i_clk);
        check(frame, exp_frame(st, sup));
        check({31'h0, rsvd}, 32'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic scen_reset;
        repeat (12) @(negedge i_clk);
        check(frame, 32'hffffffff);
        i_reset_n = 1'h1;
        apply(12'hfff, 12'hfff);
        i_reset_n = 1'h0;
        #1;
        check(frame, 32'hffffffff);
        @(negedge i_clk);
        i_reset_n = 1'h1;
        apply(12'h000, 12'hfff);
    endtask
    task automatic scen_walk;
        for (int i = 0; i < 12; i++) begin
            apply(12'h1 << i, 12'hfff);
        end
    endtask
    task automatic scen_unsup;
        for (int i = 0; i < 12; i++) begin
            apply(12'hfff, ~(12'h1 << i));
            apply(12'h000, 12'h1 << i);
        end
        apply(12'h000, 12'h000);
    endtask
    task automatic scen_mixed;
        apply(12'ha5a, 12'hc3f);
        apply(12'h5a5, 12'h3c0);
        apply(12'hfff, 12'hfff);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        scen_reset();
        scen_walk();
        scen_unsup();
        scen_mixed();
        close_out();
    end
endmodule
